/* bcs_pkg.sv */
// Package of constants and types for the battery charger state machine
// Summary of operation
// - Charging allowed and battery below precharge threshold means precharge state.
// - Precharge not passed within 30 minutes of first entry gives precharge fault.
// - Precharge current fraction and three-bit threshold select come from configuration.
// - Above precharge threshold enter constant current with six-bit current select.
// - At regulation voltage enter constant voltage; six-bit voltage select.
// - In constant voltage, current below termination level enters finish state.
// - Safety timer starts entering constant current from a non-fast-charge state.
// - Two-bit safety length 3, 5, 7 hours; code zero disables timer.
// - Safety timer expiry during any fast-charge state gives safety fault.
// - Safety timer pauses on low current or supplement; paused status shown. Low current pauses it only in the constant current states.
// - Finish timer 0 to 35 minutes on entry; expiry goes done.
// - Done keeps battery disconnected; restart when battery drops 150mV below target.
// - Precharge fault stops current; exit only by enable toggle or supply cycle. A hot or cold zone still moves it to temperature fault and back.
// - Safety fault stops current; exit only by enable toggle or supply cycle. A hot or cold zone still moves it to temperature fault and back.
// - Thermistor enabled and hot or cold enters temperature fault, no current.
// - Temperature fault outranks all but off; leave on disable or normal temperature.
// - Leaving temperature fault returns to the state held before it.
// - Precharge timer frozen in temperature fault and resumes; others held cleared.
// - Alternate states only with thermistor enabled, on warm or cool zone.
// - Alternate states use alternate current and voltage; leave on normal or disable.
// - Present temperature zone as a three-bit status field.
// - Off while supply invalid, enable low, or battery fresh.
// - Four-bit state status field with change event pulse.
package bcs_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int PRECHARGE_TIMER_MIN = 30;
    localparam int PRECHARGE_TIMER_TICKS = PRECHARGE_TIMER_MIN * 60;
    localparam int SAFETY_BASE_HOURS = 3;
    localparam int SAFETY_STEP_HOURS = 2;
    localparam int FINISH_STEP_MIN = 5;
    localparam int RESTART_MV = 150;
    localparam logic [1:0] SAFETY_OFF = 2'h0;
    localparam int TIMER_W = 16;
    localparam logic [2:0] ZONE_NORMAL = 3'h0;
    localparam logic [2:0] ZONE_COOL = 3'h1;
    localparam logic [2:0] ZONE_WARM = 3'h2;
    localparam logic [2:0] ZONE_COLD = 3'h3;
    localparam logic [2:0] ZONE_HOT = 3'h4;

    typedef enum logic [3:0] {
        BCS_OFF = 4'h0,
        BCS_PRECHARGE = 4'h1,
        BCS_CC = 4'h3,
        BCS_CV = 4'h2,
        BCS_FINISH = 4'h6,
        BCS_DONE = 4'h7,
        BCS_ALT_CC = 4'h5,
        BCS_ALT_CV = 4'h4,
        BCS_ALT_FINISH = 4'hc,
        BCS_ALT_DONE = 4'hd,
        BCS_PRE_FAULT = 4'hf,
        BCS_SAFE_FAULT = 4'he,
        BCS_TEMP_FAULT = 4'ha
    } bcs_state_t;
endpackage : bcs_pkg

/* bcs_timer_if.sv */
// Interface joining the state machine to one charger timer
`timescale 1ns/1ps
`default_nettype none
interface bcs_timer_if;
    logic clear;
    logic run;
    logic [bcs_pkg::TIMER_W-1:0] limit;
    logic expired;
    modport ctrl (output clear, output run, output limit, input expired);
    modport tmr (input clear, input run, input limit, output expired);
endinterface : bcs_timer_if
`default_nettype wire

/* bcs_timer.sv */
// Tick counting timer with clear, run and limit
`timescale 1ns/1ps
`default_nettype none
module bcs_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    bcs_timer_if.tmr t
);
    logic [bcs_pkg::TIMER_W-1:0] count_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else if (t.clear) begin
            count_reg <= '0;
        end else if (t.run && tick && count_reg < t.limit) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign t.expired = (count_reg >= t.limit);
endmodule : bcs_timer
`default_nettype wire

/* bcs_charger.sv */
// Battery charger control state machine with its three timers
`timescale 1ns/1ps
`default_nettype none
module bcs_charger #(
    parameter int TICK_CYCLES = bcs_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic charger_enable,
    input wire logic thermistor_enable,
    input wire logic precharge_current_select,
    input wire logic [2:0] precharge_threshold_select,
    input wire logic [1:0] termination_select,
    input wire logic [5:0] constant_current_select,
    input wire logic [5:0] regulation_voltage_select,
    input wire logic [5:0] alternate_current_select,
    input wire logic [5:0] alternate_voltage_select,
    input wire logic [1:0] safety_timer_select,
    input wire logic [2:0] finish_timer_select,
    input wire logic input_supply,
    input wire logic batt_below_precharge,
    input wire logic batt_at_regulation,
    input wire logic batt_below_restart,
    input wire logic current_below_term,
    input wire logic current_below_fifth,
    input wire logic supplement_active,
    input wire logic [2:0] temp_zone,
    output logic [3:0] charger_state_status,
    output logic state_changed,
    output logic [2:0] temperature_zone_status,
    output logic safety_timer_paused,
    output logic charge_on,
    output logic battery_connect,
    output logic use_alternate,
    output logic precharge_current_mode,
    output logic [2:0] precharge_threshold_out,
    output logic [1:0] termination_out,
    output logic [5:0] current_select_out,
    output logic [5:0] voltage_select_out
);
    if (TICK_CYCLES < 2) begin : g_bad
        $error("TICK_CYCLES must be at least 2");
    end

    localparam int TICK_W = $clog2(TICK_CYCLES);

    // Two-flop synchronisers for the comparator, status, enable and temperature zone inputs
    localparam int SYNC_W = 9;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [2:0] zone1_reg;
    logic [2:0] zone2_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            zone1_reg <= bcs_pkg::ZONE_NORMAL;
            zone2_reg <= bcs_pkg::ZONE_NORMAL;
        end else begin
            sync1_reg <= {input_supply, batt_below_precharge, batt_at_regulation,
                          batt_below_restart, current_below_term, current_below_fifth,
                          supplement_active, charger_enable, thermistor_enable};
            sync2_reg <= sync1_reg;
            zone1_reg <= temp_zone;
            zone2_reg <= zone1_reg;
        end
    end

    logic supply_ok, below_pq, at_reg, below_restart, below_term, below_fifth;
    logic supplement, enable_s, therm_on;
    assign {supply_ok, below_pq, at_reg, below_restart, below_term, below_fifth, supplement,
            enable_s, therm_on} = sync2_reg;

    function automatic logic zone_extreme(input logic [2:0] z);
        zone_extreme = (z == bcs_pkg::ZONE_HOT) || (z == bcs_pkg::ZONE_COLD);
    endfunction : zone_extreme

    function automatic logic zone_mild(input logic [2:0] z);
        zone_mild = (z == bcs_pkg::ZONE_WARM) || (z == bcs_pkg::ZONE_COOL);
    endfunction : zone_mild

    function automatic logic is_fast(input bcs_pkg::bcs_state_t s);
        is_fast = (s == bcs_pkg::BCS_CC) || (s == bcs_pkg::BCS_CV) ||
                  (s == bcs_pkg::BCS_ALT_CC) || (s == bcs_pkg::BCS_ALT_CV);
    endfunction : is_fast

    // Slow time base shared by every timer
    logic [TICK_W-1:0] div_reg;
    logic tick_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else if (div_reg == TICK_W'(TICK_CYCLES - 1)) begin
            div_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // Enable edge and supply loss detection
    logic enable_d_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_d_reg <= 1'b0;
        end else begin
            enable_d_reg <= enable_s;
        end
    end
    logic force_off;
    assign force_off = !supply_ok || !enable_s || (enable_d_reg && !enable_s);

    bcs_timer_if pre_t ();
    bcs_timer_if safe_t ();
    bcs_timer_if fin_t ();

    bcs_timer u_pre (.clk(clk), .rst_b(rst_b), .tick(tick_reg), .t(pre_t));
    bcs_timer u_safe (.clk(clk), .rst_b(rst_b), .tick(tick_reg), .t(safe_t));
    bcs_timer u_fin (.clk(clk), .rst_b(rst_b), .tick(tick_reg), .t(fin_t));

    bcs_pkg::bcs_state_t state_reg;
    bcs_pkg::bcs_state_t state_next;
    bcs_pkg::bcs_state_t saved_reg;
    logic temp_exit;

    logic alt_ok;
    logic extreme;
    assign alt_ok = therm_on && zone_mild(zone2_reg);
    assign extreme = therm_on && zone_extreme(zone2_reg);

    assign pre_t.limit = bcs_pkg::TIMER_W'(bcs_pkg::PRECHARGE_TIMER_TICKS);
    // Safety limit is set in minutes and counted on the minute strobe, not on one-second ticks
    assign safe_t.limit = bcs_pkg::TIMER_W'((bcs_pkg::SAFETY_BASE_HOURS +
        bcs_pkg::SAFETY_STEP_HOURS * (int'(safety_timer_select) - 1)) * 60);
    assign fin_t.limit = bcs_pkg::TIMER_W'(int'(finish_timer_select) *
                         bcs_pkg::FINISH_STEP_MIN * 60);

    logic safe_enabled;
    assign safe_enabled = (safety_timer_select != bcs_pkg::SAFETY_OFF);
    logic in_temp;
    assign in_temp = (state_reg == bcs_pkg::BCS_TEMP_FAULT);
    logic cc_state;
    assign cc_state = state_reg inside {bcs_pkg::BCS_CC, bcs_pkg::BCS_ALT_CC};
    logic safe_pause;
    assign safe_pause = (cc_state && below_fifth) || supplement;

    // Minute strobe for the safety timer
    logic [5:0] sec_reg;
    logic minute_tick;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_reg <= '0;
        end else if (tick_reg) begin
            sec_reg <= (sec_reg == 6'h3b) ? 6'h00 : sec_reg + 6'h01;
        end
    end
    assign minute_tick = (sec_reg == 6'h3b);

    always_comb begin
        pre_t.clear = force_off || (state_reg == bcs_pkg::BCS_OFF) ||
                      !(state_next inside {bcs_pkg::BCS_PRECHARGE, bcs_pkg::BCS_TEMP_FAULT,
                                           bcs_pkg::BCS_PRE_FAULT});
        pre_t.run = (state_reg == bcs_pkg::BCS_PRECHARGE);
        safe_t.clear = force_off || temp_exit || !is_fast(state_reg);
        safe_t.run = is_fast(state_reg) && !safe_pause && safe_enabled && minute_tick;
        fin_t.clear = force_off || temp_exit ||
                      (state_reg != bcs_pkg::BCS_FINISH &&
                       state_reg != bcs_pkg::BCS_ALT_FINISH);
        fin_t.run = !in_temp;
    end

    logic safe_expired;
    assign safe_expired = safe_enabled && safe_t.expired && safe_t.limit != '0;

    always_comb begin
        state_next = state_reg;
        temp_exit = 1'b0;
        if (force_off) begin
            state_next = bcs_pkg::BCS_OFF;
        end else if (extreme && !in_temp && state_reg != bcs_pkg::BCS_OFF) begin
            state_next = bcs_pkg::BCS_TEMP_FAULT;
        end else begin
            unique case (state_reg)
                bcs_pkg::BCS_OFF: begin
                    if (below_pq) begin
                        state_next = bcs_pkg::BCS_PRECHARGE;
                    end else if (below_restart) begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_CC : bcs_pkg::BCS_CC;
                    end
                end
                bcs_pkg::BCS_PRECHARGE: begin
                    if (pre_t.expired) begin
                        state_next = bcs_pkg::BCS_PRE_FAULT;
                    end else if (!below_pq) begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_CC : bcs_pkg::BCS_CC;
                    end
                end
                bcs_pkg::BCS_CC, bcs_pkg::BCS_ALT_CC: begin
                    if (safe_expired) begin
                        state_next = bcs_pkg::BCS_SAFE_FAULT;
                    end else if (at_reg) begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_CV : bcs_pkg::BCS_CV;
                    end else begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_CC : bcs_pkg::BCS_CC;
                    end
                end
                bcs_pkg::BCS_CV, bcs_pkg::BCS_ALT_CV: begin
                    if (safe_expired) begin
                        state_next = bcs_pkg::BCS_SAFE_FAULT;
                    end else if (below_term) begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_FINISH :
                                              bcs_pkg::BCS_FINISH;
                    end else begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_CV : bcs_pkg::BCS_CV;
                    end
                end
                bcs_pkg::BCS_FINISH, bcs_pkg::BCS_ALT_FINISH: begin
                    if (fin_t.expired) begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_DONE : bcs_pkg::BCS_DONE;
                    end else begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_FINISH :
                                              bcs_pkg::BCS_FINISH;
                    end
                end
                bcs_pkg::BCS_DONE, bcs_pkg::BCS_ALT_DONE: begin
                    if (below_restart) begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_CC : bcs_pkg::BCS_CC;
                    end else begin
                        state_next = alt_ok ? bcs_pkg::BCS_ALT_DONE : bcs_pkg::BCS_DONE;
                    end
                end
                bcs_pkg::BCS_PRE_FAULT, bcs_pkg::BCS_SAFE_FAULT: begin
                    state_next = state_reg;
                end
                bcs_pkg::BCS_TEMP_FAULT: begin
                    if (!extreme) begin
                        state_next = saved_reg;
                        temp_exit = 1'b1;
                    end
                end
                default: begin
                    state_next = bcs_pkg::BCS_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= bcs_pkg::BCS_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Remembers where to return after a temperature fault
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            saved_reg <= bcs_pkg::BCS_OFF;
        end else if (state_next == bcs_pkg::BCS_TEMP_FAULT && !in_temp) begin
            saved_reg <= state_reg;
        end
    end

    logic alt_state;
    logic charging;
    always_comb begin
        alt_state = state_next inside {bcs_pkg::BCS_ALT_CC, bcs_pkg::BCS_ALT_CV,
                                       bcs_pkg::BCS_ALT_FINISH, bcs_pkg::BCS_ALT_DONE};
        charging = is_fast(state_next) || state_next inside {bcs_pkg::BCS_PRECHARGE,
                   bcs_pkg::BCS_FINISH, bcs_pkg::BCS_ALT_FINISH};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            charger_state_status <= 4'h0;
            state_changed <= 1'b0;
            temperature_zone_status <= bcs_pkg::ZONE_NORMAL;
            safety_timer_paused <= 1'b0;
            charge_on <= 1'b0;
            battery_connect <= 1'b1;
            use_alternate <= 1'b0;
            precharge_current_mode <= 1'b0;
            precharge_threshold_out <= 3'h0;
            termination_out <= 2'h0;
            current_select_out <= 6'h00;
            voltage_select_out <= 6'h00;
        end else begin
            charger_state_status <= state_next;
            state_changed <= (state_next != state_reg);
            temperature_zone_status <= zone2_reg;
            safety_timer_paused <= is_fast(state_reg) && safe_pause;
            charge_on <= charging;
            // Battery stays on the system only while the supply is absent
            battery_connect <= !supply_ok;
            use_alternate <= alt_state;
            precharge_current_mode <= precharge_current_select;
            precharge_threshold_out <= precharge_threshold_select;
            termination_out <= termination_select;
            current_select_out <= alt_state ? alternate_current_select :
                                  constant_current_select;
            voltage_select_out <= alt_state ? alternate_voltage_select :
                                  regulation_voltage_select;
        end
    end
endmodule : bcs_charger
`default_nettype wire

/* bcs_charger_asserts.sv */
// Concurrent checks on the charger state machine ports
`timescale 1ns/1ps
`default_nettype none
module bcs_charger_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic charger_enable,
    input wire logic thermistor_enable,
    input wire logic input_supply,
    input wire logic [2:0] temp_zone,
    input wire logic [5:0] alternate_current_select,
    input wire logic [5:0] alternate_voltage_select,
    input wire logic [3:0] charger_state_status,
    input wire logic state_changed,
    input wire logic [2:0] temperature_zone_status,
    input wire logic charge_on,
    input wire logic battery_connect,
    input wire logic use_alternate,
    input wire logic [5:0] current_select_out,
    input wire logic [5:0] voltage_select_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_pulse;
        charger_state_status != $past(charger_state_status) |-> state_changed;
    endproperty
    a_pulse: assert property (p_pulse) else $error("status change without pulse");
    property p_fault_off;
        charger_state_status inside {bcs_pkg::BCS_PRE_FAULT, bcs_pkg::BCS_SAFE_FAULT,
            bcs_pkg::BCS_TEMP_FAULT} |-> !charge_on && !battery_connect;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("charging in fault");
    property p_done;
        charger_state_status == bcs_pkg::BCS_DONE |-> !charge_on;
    endproperty
    a_done: assert property (p_done) else $error("charging in done");
    property p_alt_sel;
        use_alternate |-> current_select_out == alternate_current_select
            && voltage_select_out == alternate_voltage_select;
    endproperty
    a_alt_sel: assert property (p_alt_sel) else $error("alternate settings unused");
    property p_charge_on;
        charge_on == (charger_state_status inside {bcs_pkg::BCS_PRECHARGE, bcs_pkg::BCS_CC,
            bcs_pkg::BCS_CV, bcs_pkg::BCS_FINISH, bcs_pkg::BCS_ALT_CC, bcs_pkg::BCS_ALT_CV,
            bcs_pkg::BCS_ALT_FINISH});
    endproperty
    a_charge_on: assert property (p_charge_on) else $error("charge_on wrong for state");
    property p_off;
        !charger_enable [*5] |-> charger_state_status == bcs_pkg::BCS_OFF;
    endproperty
    a_off: assert property (p_off) else $error("not off while disabled");
    property p_supply;
        !input_supply [*5] |-> charger_state_status == bcs_pkg::BCS_OFF && battery_connect;
    endproperty
    a_supply: assert property (p_supply) else $error("not off without supply");
    property p_thm;
        !thermistor_enable [*5] |-> !use_alternate
            && charger_state_status != bcs_pkg::BCS_TEMP_FAULT;
    endproperty
    a_thm: assert property (p_thm) else $error("temperature state while disabled");
    property p_zone;
        $stable(temp_zone) [*4] |-> temperature_zone_status == temp_zone;
    endproperty
    a_zone: assert property (p_zone) else $error("zone status stale");
    c_done: cover property (charger_state_status == bcs_pkg::BCS_DONE);
    c_temp: cover property (charger_state_status == bcs_pkg::BCS_TEMP_FAULT);
    c_alt: cover property (use_alternate);
endmodule : bcs_charger_asserts
bind bcs_charger bcs_charger_asserts chk_u (.clk, .rst_b, .charger_enable, .thermistor_enable,
    .input_supply, .temp_zone, .alternate_current_select, .alternate_voltage_select,
    .charger_state_status, .state_changed, .temperature_zone_status, .charge_on,
    .battery_connect, .use_alternate, .current_select_out, .voltage_select_out);
`default_nettype wire

/* bcs_batt_model.sv */
// Cell and comparator model facing the charger
`timescale 1ns/1ps
`default_nettype none
module bcs_batt_model (
    input wire logic clk,
    input wire logic charge_on,
    input wire logic hold,
    input wire logic drain,
    output logic batt_below_precharge,
    output logic batt_at_regulation,
    output logic batt_below_restart,
    output logic current_below_term
);
    logic [7:0] level_reg = 8'h00;
    // Drain wins so a test can always empty the cell
    always_ff @(negedge clk) begin
        if (drain && level_reg != 8'h00) begin
            level_reg <= level_reg - 8'h01;
        end else if (charge_on && !hold && level_reg != 8'hff) begin
            level_reg <= level_reg + 8'h01;
        end
    end
    assign batt_below_precharge = level_reg < 8'h20;
    assign batt_at_regulation = level_reg >= 8'h60;
    assign batt_below_restart = level_reg < 8'h50;
    // Taper modelled as further charge past regulation
    assign current_below_term = level_reg >= 8'h80;
endmodule : bcs_batt_model
`default_nettype wire

/* tb_bcs_charger.sv */
// Self-checking testbench for the charger state machine
`timescale 1ns/1ps
`default_nettype none
module tb_bcs_charger;
    localparam int TK = 2;
    localparam int PT = bcs_pkg::PRECHARGE_TIMER_TICKS * TK;
    localparam int SF = bcs_pkg::SAFETY_BASE_HOURS * 3600 * TK;
    logic clk, rst_b, charger_enable, thermistor_enable, precharge_current_select;
    logic input_supply, current_below_fifth, supplement_active, hold, drain;
    logic [2:0] precharge_threshold_select, finish_timer_select, temp_zone;
    logic [1:0] termination_select, safety_timer_select;
    logic [5:0] constant_current_select, regulation_voltage_select;
    logic [5:0] alternate_current_select, alternate_voltage_select;
    logic batt_below_precharge, batt_at_regulation, batt_below_restart, current_below_term;
    logic [3:0] charger_state_status;
    logic state_changed, safety_timer_paused, charge_on, battery_connect, use_alternate;
    logic precharge_current_mode;
    logic [2:0] temperature_zone_status, precharge_threshold_out;
    logic [1:0] termination_out;
    logic [5:0] current_select_out, voltage_select_out;
    int mismatches = 0;
    int samples_checked = 0;
    integer seed = 32'h0000_bfd3;
    bcs_charger #(.TICK_CYCLES(TK)) dut_u (
        .clk, .rst_b, .charger_enable, .thermistor_enable, .precharge_current_select,
        .precharge_threshold_select, .termination_select, .constant_current_select,
        .regulation_voltage_select, .alternate_current_select, .alternate_voltage_select,
        .safety_timer_select, .finish_timer_select, .input_supply, .batt_below_precharge,
        .batt_at_regulation, .batt_below_restart, .current_below_term, .current_below_fifth,
        .supplement_active, .temp_zone, .charger_state_status, .state_changed,
        .temperature_zone_status, .safety_timer_paused, .charge_on, .battery_connect,
        .use_alternate, .precharge_current_mode, .precharge_threshold_out, .termination_out,
        .current_select_out, .voltage_select_out);
    bcs_batt_model batt_u (.clk, .charge_on, .hold, .drain, .batt_below_precharge,
        .batt_at_regulation, .batt_below_restart, .current_below_term);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [7:0] exp_cur(input logic alt);
        return alt ? 8'(alternate_current_select) : 8'(constant_current_select);
    endfunction : exp_cur
    task automatic complete_run();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wait_state(input logic [3:0] code, input int limit);
        int n = 0;
        while (charger_state_status !== code && n < limit) begin
            cyc(1);
            n++;
        end
        check("state", 8'(code), 8'(charger_state_status));
    endtask : wait_state
    // Empties the cell while disabled so every run starts deep
    task automatic start(input logic [1:0] sel, input logic [2:0] fin);
        charger_enable = 1'b0;
        drain = 1'b1;
        cyc(260);
        drain = 1'b0;
        safety_timer_select = sel;
        finish_timer_select = fin;
        {precharge_current_select, precharge_threshold_select,
         termination_select} = 6'($random(seed));
        {constant_current_select, regulation_voltage_select} = 12'($random(seed));
        {alternate_current_select, alternate_voltage_select} = 12'($random(seed));
        charger_enable = 1'b1;
    endtask : start
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        {charger_enable, thermistor_enable, precharge_current_select, input_supply} = 4'h0;
        {current_below_fifth, supplement_active, hold, drain, rst_b} = 5'h00;
        {precharge_threshold_select, finish_timer_select, temp_zone} = 9'h000;
        {termination_select, safety_timer_select} = 4'h0;
        {constant_current_select, regulation_voltage_select} = 12'h000;
        {alternate_current_select, alternate_voltage_select} = 12'h000;
        cyc(12);
        check("status", 8'h00, 8'(charger_state_status));
        check("connect", 8'h01, 8'(battery_connect));
        rst_b = 1'b1;
        input_supply = 1'b1;
        start(2'h0, 3'h0);
        wait_state(4'h1, 20);
        check("pq_cur", 8'(precharge_current_select), 8'(precharge_current_mode));
        check("pq_thr", 8'(precharge_threshold_select), 8'(precharge_threshold_out));
        check("term", 8'(termination_select), 8'(termination_out));
        wait_state(4'h3, 60);
        check("cur", exp_cur(1'b0), 8'(current_select_out));
        wait_state(4'h2, 80);
        check("volt", 8'(regulation_voltage_select), 8'(voltage_select_out));
        wait_state(4'h6, 60);
        wait_state(4'h7, 10);
        drain = 1'b1;
        cyc(70);
        check("restart", 8'h01, 8'(charge_on));
        hold = 1'b1;
        start(2'h0, 3'h0);
        wait_state(4'h1, 20);
        cyc(PT - 200);
        check("pq_early", 8'h01, 8'(charger_state_status));
        wait_state(4'hf, 400);
        hold = 1'b0;
        temp_zone = bcs_pkg::ZONE_WARM;
        cyc(20);
        check("pq_held", 8'h0f, 8'(charger_state_status));
        temp_zone = bcs_pkg::ZONE_NORMAL;
        charger_enable = 1'b0;
        wait_state(4'h0, 10);
        charger_enable = 1'b1;
        wait_state(4'h1, 10);
        thermistor_enable = 1'b1;
        start(2'h1, 3'h0);
        wait_state(4'h3, 60);
        hold = 1'b1;
        temp_zone = bcs_pkg::ZONE_WARM;
        wait_state(4'h5, 10);
        check("alt_cur", exp_cur(1'b1), 8'(current_select_out));
        check("alt", 8'h01, 8'(use_alternate));
        check("zone", 8'(bcs_pkg::ZONE_WARM), 8'(temperature_zone_status));
        temp_zone = bcs_pkg::ZONE_NORMAL;
        wait_state(4'h3, 10);
        cyc(SF / 2);
        temp_zone = bcs_pkg::ZONE_HOT;
        wait_state(4'ha, 10);
        cyc(100);
        temp_zone = bcs_pkg::ZONE_NORMAL;
        wait_state(4'h3, 10);
        cyc(SF - 2000);
        check("restarted", 8'h03, 8'(charger_state_status));
        for (int i = 0; i < 2; i++) begin
            {current_below_fifth, supplement_active} = 2'h1 << i;
            cyc(6);
            check("paused", 8'h01, 8'(safety_timer_paused));
            {current_below_fifth, supplement_active} = 2'h0;
            cyc(6);
        end
        wait_state(4'he, 2600);
        input_supply = 1'b0;
        wait_state(4'h0, 10);
        input_supply = 1'b1;
        hold = 1'b0;
        thermistor_enable = 1'b0;
        temp_zone = bcs_pkg::ZONE_HOT;
        start(2'h0, 3'h0);
        wait_state(4'h3, 60);
        hold = 1'b1;
        cyc(SF + 1000);
        check("no_timer", 8'h03, 8'(charger_state_status));
        check("zone", 8'(bcs_pkg::ZONE_HOT), 8'(temperature_zone_status));
        complete_run();
    end
endmodule : tb_bcs_charger
`default_nettype wire
